// ==== design/scm_pkg.sv ====
package scm_pkg;

    // register bus geometry
    localparam int SCM_ADDR_W = 8;
    localparam int SCM_DATA_W = 16;

    // register offsets
    localparam logic [7:0] SCM_OFS_COMM_TIMEOUT_CONFIG = 8'h02;
    localparam logic [7:0] SCM_OFS_SUPPLY_CONFIG = 8'h03;
    localparam logic [7:0] SCM_OFS_POWER_MODE_CONTROL = 8'h04;
    localparam logic [7:0] SCM_OFS_UNIT_STATUS = 8'h10;

    // comm_timeout_config fields
    localparam int SCM_TO_PERIOD_LSB = 0;
    localparam int SCM_TO_KEY_LSB = 8;
    localparam logic [7:0] SCM_TO_PERIOD_RESET = 8'h1e;
    localparam logic [7:0] SCM_TO_KEY_RESET = 8'h00;
    localparam logic [7:0] SCM_TO_KEY_DISABLE = 8'h5a;

    // supply_config fields
    localparam int SCM_SUP_CURRENT_MATCHING_ENABLE_BIT = 15;
    localparam int SCM_SUP_CORE_CYC_BIT = 2;
    localparam int SCM_SUP_AUX_CYC_BIT = 1;
    localparam int SCM_SUP_AUX_ACT_BIT = 0;
    localparam logic SCM_SUP_CURRENT_MATCHING_ENABLE_RESET = 1'b1;
    localparam logic SCM_SUP_CORE_CYC_RESET = 1'b0;
    localparam logic SCM_SUP_AUX_CYC_RESET = 1'b1;
    localparam logic SCM_SUP_AUX_ACT_RESET = 1'b1;

    // power_mode_control fields and mode codes
    localparam int SCM_MODE_REQ_LSB = 0;
    localparam int SCM_MODE_LAST_LSB = 8;
    localparam logic [4:0] SCM_MODE_SLEEP = 5'h0a;
    localparam logic [4:0] SCM_MODE_DEEP_SLEEP = 5'h14;
    localparam logic [4:0] SCM_MODE_CYCLIC = 5'h1f;
    localparam logic [4:0] SCM_MODE_LAST_RESET = 5'h14;

    // unit_status fields
    localparam int SCM_STAT_EXPIRED_BIT = 0;
    localparam int SCM_STAT_DISABLED_BIT = 1;
    localparam int SCM_STAT_PENDING_BIT = 2;

    // timing
    localparam int SCM_CLK_FREQ_HZ = 10_000_000;
    localparam int SCM_TIMEOUT_UNIT_MS = 10;
    localparam int SCM_TIMEOUT_UNIT_CYCLES = SCM_CLK_FREQ_HZ / 1000 * SCM_TIMEOUT_UNIT_MS;
    localparam int SCM_TICK_W = 17;

    // power mode seen by the supply gating
    typedef enum logic [1:0] {
        SCM_PWR_ACTIVE,
        SCM_PWR_CYCLIC,
        SCM_PWR_LOW
    } scm_pwr_state_t;

endpackage

// ==== design/scm_timeout_timer.sv ====
`timescale 1ns/100ps
module scm_timeout_timer
    import scm_pkg::*;
#(
    parameter int TICK_CYCLES = SCM_TIMEOUT_UNIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic enable,
    input wire logic [7:0] period,
    input wire logic restart,
    // result
    output logic expired
);

    localparam logic [SCM_TICK_W-1:0] TICK_LAST = SCM_TICK_W'(TICK_CYCLES - 1);

    logic [SCM_TICK_W-1:0] tick_reg;
    logic [SCM_TICK_W-1:0] tick_next;
    logic [7:0] unit_reg;
    logic [7:0] unit_next;
    logic expired_reg;
    logic expired_next;

    wire tick_wrap = (tick_reg == TICK_LAST);
    // zero period behaves as one unit
    wire [7:0] period_eff = (period == 8'h00) ? 8'h01 : period; // see [RQ1]
    wire unit_done = tick_wrap && ({1'b0, unit_reg} + 9'h001 >= {1'b0, period_eff}); // see [RQ1]

    always_comb begin
        tick_next = tick_reg;
        unit_next = unit_reg;
        expired_next = expired_reg;
        if (!enable || restart) begin // see [RQ15]
            tick_next = '0;
            unit_next = '0;
            expired_next = 1'b0;
        end else if (!expired_reg) begin
            if (unit_done) begin
                tick_next = '0;
                unit_next = '0;
                expired_next = 1'b1; // see [RQ15]
            end else if (tick_wrap) begin
                tick_next = '0;
                unit_next = unit_reg + 8'h01;
            end else begin
                tick_next = tick_reg + SCM_TICK_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tick_reg <= '0;
            unit_reg <= '0;
            expired_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            unit_reg <= unit_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;

endmodule // scm_timeout_timer

// ==== design/scm_sys_config.sv ====
//////////////////////////////////////////////////////////////////////////////////////////
// Contract
// [RQ1] timeout period is the 8-bit period field times 10 ms, zero acting as one.
// [RQ2] after reset the period field holds 1Eh, a 300 ms timeout.
// [RQ3] the timeout is off only while the key field holds 5Ah, and reset leaves it 00h.
// [RQ4] software writes the disable key only during development, never in production.
// [RQ5] supply bit 15 enables supply current matching in active mode and resets to one; the code drives current_matching_enable from the bit in every power mode.
// [RQ6] supply bit 2 keeps the core supply on in cyclic mode when set and resets to zero.
// [RQ7] supply bit 1 keeps the aux supply on in cyclic mode when set and resets to one.
// [RQ8] supply bit 0 keeps the aux supply on in active mode when set and resets to one.
// [RQ9] reserved bits are read-only and always read zero.
// [RQ10] bits 12:8 of the mode register report the low-power mode last left.
// [RQ11] after reset the last-mode field reads the deep sleep code 14h.
// [RQ12] software treats any last-mode value other than the three codes as invalid.
// [RQ13] writing 0Ah or 14h to the target field starts the mode transition at once.
// [RQ14] any other target code is ignored and the mode stays unchanged.
// [RQ15] the timeout restarts on each valid host command and flags expiry when it runs out.
//////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module scm_sys_config
    import scm_pkg::*;
#(
    parameter int TICK_CYCLES = SCM_TIMEOUT_UNIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [SCM_ADDR_W-1:0] reg_addr,
    input wire logic [SCM_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [SCM_DATA_W-1:0] reg_rdata,
    // host command activity
    input wire logic host_cmd_valid,
    // power state from the mode sequencer
    input wire logic in_active_mode,
    input wire logic in_cyclic_mode,
    input wire logic mode_exit_valid,
    input wire logic [4:0] mode_exit_code,
    // mode transition request
    output logic mode_request,
    output logic [4:0] requested_mode,
    // supply controls
    output logic current_matching_enable,
    output logic core_supply_output,
    output logic aux_supply_output,
    // timeout
    output logic timeout_expired
);

    //////////////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] timeout_period_reg;
    logic [7:0] timeout_disable_key_reg;
    logic current_matching_enable_reg;
    logic core_supply_cyclic_enable_reg;
    logic aux_supply_cyclic_enable_reg;
    logic aux_supply_active_enable_reg;
    logic [4:0] last_mode_report_reg;
    logic mode_request_reg;
    logic [4:0] requested_mode_reg;
    logic mode_pending_reg;
    logic mode_pending_next;
    logic core_supply_output_reg;
    logic core_supply_output_next;
    logic aux_supply_output_reg;
    logic aux_supply_output_next;
    logic [SCM_DATA_W-1:0] reg_rdata_reg;
    logic [SCM_DATA_W-1:0] reg_rdata_next;
    scm_pwr_state_t pwr_state;
    logic timer_expired;

    //////////////////////////////////////////////////////////////////////////////////////
    // address decode

    wire sel_timeout = (reg_addr == SCM_OFS_COMM_TIMEOUT_CONFIG);
    wire sel_supply = (reg_addr == SCM_OFS_SUPPLY_CONFIG);
    wire sel_mode = (reg_addr == SCM_OFS_POWER_MODE_CONTROL);
    wire sel_status = (reg_addr == SCM_OFS_UNIT_STATUS);

    wire wr_timeout = reg_write && sel_timeout;
    wire wr_supply = reg_write && sel_supply;
    wire wr_mode = reg_write && sel_mode;

    wire [4:0] wr_target = reg_wdata[SCM_MODE_REQ_LSB +: 5];
    wire target_known = (wr_target == SCM_MODE_SLEEP) ||
                        (wr_target == SCM_MODE_DEEP_SLEEP); // see [RQ14]
    wire mode_start = wr_mode && target_known; // see [RQ13]

    wire exit_known = (mode_exit_code == SCM_MODE_SLEEP) ||
                      (mode_exit_code == SCM_MODE_DEEP_SLEEP) ||
                      (mode_exit_code == SCM_MODE_CYCLIC);

    //////////////////////////////////////////////////////////////////////////////////////
    // timeout enable and timer

    wire timeout_enabled = (timeout_disable_key_reg != SCM_TO_KEY_DISABLE); // see [RQ3]

    scm_timeout_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk(clk),
        .resetn(resetn),
        .enable(timeout_enabled),
        .period(timeout_period_reg), // see [RQ1]
        .restart(host_cmd_valid), // see [RQ15]
        .expired(timer_expired)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // read data, reserved bits and the write-only target field read zero

    wire [SCM_DATA_W-1:0] rd_timeout = {timeout_disable_key_reg, timeout_period_reg};
    wire [SCM_DATA_W-1:0] rd_supply = {current_matching_enable_reg, 12'h000,
                                       core_supply_cyclic_enable_reg,
                                       aux_supply_cyclic_enable_reg,
                                       aux_supply_active_enable_reg}; // see [RQ9]
    wire [SCM_DATA_W-1:0] rd_mode = {3'b000, last_mode_report_reg, 8'h00}; // see [RQ9] [RQ10]
    wire [SCM_DATA_W-1:0] rd_status = {13'h0000, mode_pending_reg, ~timeout_enabled,
                                       timer_expired};

    wire [SCM_DATA_W-1:0] rd_mux = sel_timeout ? rd_timeout :
                                   sel_supply ? rd_supply :
                                   sel_mode ? rd_mode :
                                   sel_status ? rd_status :
                                   16'h0000;

    always_comb begin
        reg_rdata_next = 16'h0000;
        if (reg_read) begin
            reg_rdata_next = rd_mux;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // power state and supply gating

    assign pwr_state = in_active_mode ? SCM_PWR_ACTIVE :
                       in_cyclic_mode ? SCM_PWR_CYCLIC :
                       SCM_PWR_LOW;

    always_comb begin
        core_supply_output_next = 1'b0;
        aux_supply_output_next = 1'b0;
        case (pwr_state)
            SCM_PWR_ACTIVE: begin
                core_supply_output_next = 1'b1;
                aux_supply_output_next = aux_supply_active_enable_reg; // see [RQ8]
            end
            SCM_PWR_CYCLIC: begin
                core_supply_output_next = core_supply_cyclic_enable_reg; // see [RQ6]
                aux_supply_output_next = aux_supply_cyclic_enable_reg; // see [RQ7]
            end
            default: begin
                core_supply_output_next = 1'b0;
                aux_supply_output_next = 1'b0;
            end
        endcase
    end

    // pending holds from the request until the sequencer reports an exit
    always_comb begin
        mode_pending_next = mode_pending_reg;
        if (mode_exit_valid) begin
            mode_pending_next = 1'b0;
        end
        if (mode_start) begin
            mode_pending_next = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // timeout register

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timeout_period_reg <= SCM_TO_PERIOD_RESET; // see [RQ2]
            timeout_disable_key_reg <= SCM_TO_KEY_RESET; // see [RQ3]
        end else if (wr_timeout) begin
            timeout_period_reg <= reg_wdata[SCM_TO_PERIOD_LSB +: 8];
            timeout_disable_key_reg <= reg_wdata[SCM_TO_KEY_LSB +: 8];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // supply register

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_matching_enable_reg <= SCM_SUP_CURRENT_MATCHING_ENABLE_RESET; // see [RQ5]
            core_supply_cyclic_enable_reg <= SCM_SUP_CORE_CYC_RESET; // see [RQ6]
            aux_supply_cyclic_enable_reg <= SCM_SUP_AUX_CYC_RESET; // see [RQ7]
            aux_supply_active_enable_reg <= SCM_SUP_AUX_ACT_RESET; // see [RQ8]
        end else if (wr_supply) begin
            current_matching_enable_reg <= reg_wdata[SCM_SUP_CURRENT_MATCHING_ENABLE_BIT]; // see [RQ5]
            core_supply_cyclic_enable_reg <= reg_wdata[SCM_SUP_CORE_CYC_BIT];
            aux_supply_cyclic_enable_reg <= reg_wdata[SCM_SUP_AUX_CYC_BIT];
            aux_supply_active_enable_reg <= reg_wdata[SCM_SUP_AUX_ACT_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // mode register: last mode report and request pulse

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_mode_report_reg <= SCM_MODE_LAST_RESET; // see [RQ11]
        end else if (mode_exit_valid && exit_known) begin
            last_mode_report_reg <= mode_exit_code; // see [RQ10]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode_request_reg <= 1'b0;
            requested_mode_reg <= 5'h00;
            mode_pending_reg <= 1'b0;
        end else begin
            mode_request_reg <= mode_start; // see [RQ13]
            if (mode_start) begin
                requested_mode_reg <= wr_target; // see [RQ14]
            end
            mode_pending_reg <= mode_pending_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_reg <= 16'h0000;
            core_supply_output_reg <= 1'b0;
            aux_supply_output_reg <= 1'b0;
        end else begin
            reg_rdata_reg <= reg_rdata_next;
            core_supply_output_reg <= core_supply_output_next;
            aux_supply_output_reg <= aux_supply_output_next;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign mode_request = mode_request_reg;
    assign requested_mode = requested_mode_reg;
    assign current_matching_enable = current_matching_enable_reg;
    assign core_supply_output = core_supply_output_reg;
    assign aux_supply_output = aux_supply_output_reg;
    assign timeout_expired = timer_expired;

endmodule // scm_sys_config

// ==== sim/scm_sys_config_checker.sv ====
`timescale 1ns/100ps
module scm_sys_config_checker
    import scm_pkg::*;
#(
    parameter int TICK_CYCLES = SCM_TIMEOUT_UNIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [SCM_ADDR_W-1:0] reg_addr,
    input wire logic [SCM_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [SCM_DATA_W-1:0] reg_rdata,
    // host and sequencer
    input wire logic host_cmd_valid,
    input wire logic in_active_mode,
    input wire logic in_cyclic_mode,
    input wire logic mode_exit_valid,
    input wire logic [4:0] mode_exit_code,
    // outputs
    input wire logic mode_request,
    input wire logic [4:0] requested_mode,
    input wire logic current_matching_enable,
    input wire logic core_supply_output,
    input wire logic aux_supply_output,
    input wire logic timeout_expired
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire wr_mode = reg_write && reg_addr == SCM_OFS_POWER_MODE_CONTROL;
    wire legal = reg_wdata[4:0] == SCM_MODE_SLEEP || reg_wdata[4:0] == SCM_MODE_DEEP_SLEEP;
    wire wr_legal = wr_mode && legal;
    wire wr_sup = reg_write && reg_addr == SCM_OFS_SUPPLY_CONFIG;
    wire wr_key = reg_write && reg_addr == SCM_OFS_COMM_TIMEOUT_CONFIG
        && reg_wdata[15:8] == SCM_TO_KEY_DISABLE;
    wire rd_sup = reg_read && reg_addr == SCM_OFS_SUPPLY_CONFIG;
    wire rd_mode = reg_read && reg_addr == SCM_OFS_POWER_MODE_CONTROL;
    wire exit_ok = mode_exit_valid && (mode_exit_code == SCM_MODE_SLEEP
        || mode_exit_code == SCM_MODE_DEEP_SLEEP || mode_exit_code == SCM_MODE_CYCLIC);
    wire low_pwr = !in_active_mode && !in_cyclic_mode;
    ////////////////////////////////////////////////////////////////////////////////
    mode_start_a: assert property (
        wr_legal |=> mode_request && requested_mode == $past(reg_wdata[4:0]))
        else $error("legal target write without request");
    mode_ignore_a: assert property (
        wr_mode && !legal |=> !mode_request && $stable(requested_mode))
        else $error("illegal target write acted on");
    req_cause_a: assert property (mode_request |-> $past(wr_legal))
        else $error("request without legal write");
    match_wr_a: assert property (
        wr_sup |=> ##1 current_matching_enable == $past(reg_wdata[15], 2))
        else $error("matching enable not bit 15");
    supply_act_a: assert property (
        wr_sup && in_active_mode ##1 in_active_mode
        |=> aux_supply_output == $past(reg_wdata[0], 2) && core_supply_output)
        else $error("active supply wrong");
    supply_cyc_a: assert property (
        wr_sup && in_cyclic_mode && !in_active_mode ##1 in_cyclic_mode && !in_active_mode
        |=> core_supply_output == $past(reg_wdata[2], 2)
        && aux_supply_output == $past(reg_wdata[1], 2))
        else $error("cyclic supply wrong");
    supply_off_a: assert property (
        $past(low_pwr) |-> !core_supply_output && !aux_supply_output)
        else $error("supply on in low power");
    rsv_sup_a: assert property ($past(rd_sup) |-> reg_rdata[14:3] == 12'h000)
        else $error("supply reserved bits set");
    rsv_mode_a: assert property (
        $past(rd_mode) |-> reg_rdata[15:13] == 3'h0 && reg_rdata[7:0] == 8'h00)
        else $error("mode reserved bits set");
    last_mode_a: assert property (
        exit_ok ##2 rd_mode |=> reg_rdata[12:8] == $past(mode_exit_code, 3))
        else $error("last mode not reported");
    to_clear_a: assert property (host_cmd_valid |=> !timeout_expired [*4])
        else $error("expiry too early");
    // the key lands one edge after the write, the cleared flag one edge later
    to_key_a: assert property (wr_key |-> ##2 !timeout_expired)
        else $error("expiry with key set");
    cover property (wr_legal ##1 mode_request);
    cover property ($rose(timeout_expired));
    cover property (exit_ok ##2 rd_mode);
endmodule // scm_sys_config_checker

bind scm_sys_config scm_sys_config_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .host_cmd_valid(host_cmd_valid), .in_active_mode(in_active_mode),
    .in_cyclic_mode(in_cyclic_mode), .mode_exit_valid(mode_exit_valid),
    .mode_exit_code(mode_exit_code), .mode_request(mode_request),
    .requested_mode(requested_mode), .current_matching_enable(current_matching_enable),
    .core_supply_output(core_supply_output), .aux_supply_output(aux_supply_output),
    .timeout_expired(timeout_expired));

// ==== sim/scm_sys_config_tb.sv ====
`timescale 1ns/100ps
module scm_sys_config_tb
    import scm_pkg::*;
;
    localparam int TK = 4;
    localparam logic [7:0] TO = SCM_OFS_COMM_TIMEOUT_CONFIG;
    localparam logic [7:0] SUP = SCM_OFS_SUPPLY_CONFIG;
    localparam logic [7:0] MD = SCM_OFS_POWER_MODE_CONTROL;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic host_cmd_valid = 1'b0;
    logic in_active_mode = 1'b1;
    logic in_cyclic_mode = 1'b0;
    logic mode_exit_valid = 1'b0;
    logic [4:0] mode_exit_code = 5'h00;
    logic [15:0] reg_rdata;
    logic [4:0] requested_mode;
    logic mode_request, current_matching_enable, core_supply_output, aux_supply_output;
    logic timeout_expired;
    int n_mismatch = 0;
    int n_checks = 0;
    always #50 clk = ~clk;
    scm_sys_config #(.TICK_CYCLES(TK)) dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .host_cmd_valid(host_cmd_valid), .in_active_mode(in_active_mode),
        .in_cyclic_mode(in_cyclic_mode), .mode_exit_valid(mode_exit_valid),
        .mode_exit_code(mode_exit_code), .mode_request(mode_request),
        .requested_mode(requested_mode), .current_matching_enable(current_matching_enable),
        .core_supply_output(core_supply_output), .aux_supply_output(aux_supply_output),
        .timeout_expired(timeout_expired));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(TO, 16'h001e);
        rd(SUP, 16'h8003);
        rd(MD, 16'h1400);
        rd(8'h07, 16'h0000);
        chk(current_matching_enable, 1'b1);
    endtask
    task automatic t_access();
        wr(TO, 16'hffff);
        rd(TO, 16'hffff);
        wr(SUP, 16'hffff);
        rd(SUP, 16'h8007);
        wr(MD, 16'hffff);
        rd(MD, 16'h1400);
        wr(8'h07, 16'hffff);
        rd(8'h07, 16'h0000);
        wr(SUP, 16'h0000);
        @(posedge clk);
        #1 chk(current_matching_enable, 1'b0);
    endtask
    task automatic t_mode();
        logic [4:0] last;
        logic ok;
        last = 5'h00;
        for (int c = 0; c < 32; c++) begin
            ok = c[4:0] === SCM_MODE_SLEEP || c[4:0] === SCM_MODE_DEEP_SLEEP;
            if (ok) last = c[4:0];
            wr(MD, {11'h000, c[4:0]});
            #1 chk(mode_request, ok);
            chk(requested_mode, last);
        end
    endtask
    task automatic t_exit();
        logic [4:0] codes [4] = '{5'h0a, 5'h05, 5'h1f, 5'h14};
        logic [4:0] last;
        last = 5'h14;
        foreach (codes[i]) begin
            @(posedge clk);
            mode_exit_valid <= 1'b1;
            mode_exit_code <= codes[i];
            @(posedge clk);
            mode_exit_valid <= 1'b0;
            if (codes[i] != 5'h05) last = codes[i];
            rd(MD, {3'h0, last, 8'h00});
        end
    endtask
    task automatic t_supply();
        logic [2:0] v;
        logic ec, ea;
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 8; i++) begin
                v = i[2:0];
                @(posedge clk);
                in_active_mode <= (m == 0);
                in_cyclic_mode <= (m != 2);
                ec = (m == 0) ? 1'b1 : (m == 1) ? v[2] : 1'b0;
                ea = (m == 0) ? v[0] : (m == 1) ? v[1] : 1'b0;
                wr(SUP, {13'h0000, v});
                repeat (2) @(posedge clk);
                #1 chk(core_supply_output, ec);
                chk(aux_supply_output, ea);
            end
        end
    endtask
    task automatic t_to(input logic [7:0] p);
        int n;
        n = (p == 8'h00) ? TK : p * TK;
        wr(TO, {8'h00, p});
        @(posedge clk);
        host_cmd_valid <= 1'b1;
        @(posedge clk);
        host_cmd_valid <= 1'b0;
        // expiry lands on the edge n cycles after the restart edge
        repeat (n - 1) @(posedge clk);
        #1 chk(timeout_expired, 1'b0);
        @(posedge clk);
        #1 chk(timeout_expired, 1'b1);
    endtask
    task automatic t_key();
        wr(TO, 16'h5a01);
        repeat (3 * TK) @(posedge clk);
        #1 chk(timeout_expired, 1'b0);
        rd(SCM_OFS_UNIT_STATUS, 16'h0002);
        wr(TO, 16'h0001);
        repeat (TK + 2) @(posedge clk);
        #1 chk(timeout_expired, 1'b1);
        rd(SCM_OFS_UNIT_STATUS, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_access();
        t_mode();
        t_exit();
        t_supply();
        t_to(8'h00);
        t_to(8'h01);
        t_to(8'h02);
        t_to(8'hff);
        t_key();
        print_verdict();
    end
    // watchdog well beyond the roughly 1300 cycles the tests need
    initial begin
        #(100 * 6000);
        n_mismatch++;
        print_verdict();
    end
endmodule // scm_sys_config_tb
